// ---- logic/preamble_detect_auto_tx.sv ----
// preamble detector, invalid preamble qualifier and tx retransmit/auto-tx with wishbone regs
// Notes on behaviour
// R1: tx preamble length 1..511 from nine-bit field
// R2: detect threshold is preath times four bits
// R3: false detect without sync resumes search
// R4: detect on gpio and in status registers
// R5: host sets 20 bit threshold when idle-listening
// R6: host uses 20 bit threshold with diversity
// R7: host may use 8 bit when synchronous
// R8: host sizes preamble: settling plus threshold
// R9: preamble error raises invalid flag immediately
// R10: both events in status one and two; status one here holds only the invalid event
// R11: invalid flag raised when preamble not valid
// R12: invalid flag blanked 16 bits after enable
// R13: host sends preamble long enough for blanking
// R14: host masks invalid interrupt with diversity
// R15: txon without new packet retransmits last
// R16: retransmit only packets wholly in fifo
// R17: auto tx at almost full, idle after
// R18: sync still needed, later bits raw
// R19: rx entry or exit clears and rearms
// R20: preamble is alternating ones and zeros
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
module preamble_detect_auto_tx
  import preamble_pkg::*;
(
  input  wire logic       clk_i,           // 50 mhz system clock
  input  wire logic       rst_i,           // synchronous, active high
  input  wire logic       cyc_i,           // wishbone cycle
  input  wire logic       stb_i,           // wishbone strobe
  input  wire logic       we_i,            // wishbone write
  input  wire logic [7:0] adr_i,           // byte address
  input  wire logic [3:0] sel_i,           // byte lanes, lane 0 used
  input  wire logic [31:0] dat_i,          // write data
  output logic      [31:0] dat_o,          // read data
  output logic            ack_o,           // wishbone ack
  input  wire logic       rx_bit_i,        // demodulated bit
  input  wire logic       rx_bit_en_i,     // one pulse per bit period
  input  wire logic       sync_found_i,    // sync word seen by framer
  input  wire logic       fifo_new_pkt_i,  // a new packet was written to tx fifo
  input  wire logic       fifo_fits_i,     // whole packet held in tx fifo
  input  wire logic       fifo_afull_i,    // tx fifo almost full
  input  wire logic       tx_done_i,       // packet sent
  output logic            preamble_detect_o,       // live detect
  output logic            invalid_preamble_flag_o, // live invalid indication
  output logic            gpio_o,          // selected gpio function
  output logic            rx_raw_o,        // past sync, bits are raw data
  output logic            tx_active_o,     // in transmit state
  output logic            retransmit_o,    // fifo replays last packet
  output logic            circular_o,      // fifo streams circularly
  output logic      [8:0] tx_pre_len_o     // preamble length field
);

  // byte-lane decode used for every write
  function automatic logic lane_write(input logic [3:0] sel);
    return sel[0];
  endfunction : lane_write

  // bus state
  logic       ack_reg;      // answer given this cycle
  logic [31:0] dat_reg;     // registered read data
  logic       req;          // live request
  logic       wr_take;      // write takes effect at this edge
  // software registers
  logic [7:0] ctrl_reg;     // rx enable and gpio select
  logic [7:0] opfc2_reg;    // operating_function_control_two
  logic [7:0] pre_len_reg;  // length low byte
  logic       pre_hi_reg;   // length bit 8
  logic [7:0] pre_det_reg;  // threshold field
  pre_event_t sticky_reg;   // sticky status events
  // receive logic
  rx_state_t  rx_reg;       // search state
  logic       rxen_d_reg;   // last rx enable for edge detect
  logic       last_bit_reg; // previous bit for alternation
  logic [6:0] run_reg;      // alternating run length
  logic [5:0] wait_reg;     // bit counter for blank and sync wait
  logic       det_reg;      // live detect
  logic       inv_reg;      // live invalid
  pre_event_t ev;           // events this cycle
  logic [6:0] thresh;       // threshold in bits
  logic       rxen;         // rx enable bit
  logic       rx_edge;      // rx entered or left
  // transmit logic
  tx_state_t  tx_reg;
  logic       newpkt_reg;   // packet loaded since last tx
  logic       retx_reg;
  logic       circ_reg;
  logic       txon_pulse;   // write of txon bit

  assign req        = cyc_i & stb_i;
  assign wr_take    = req & we_i & ack_reg & lane_write(sel_i);
  assign rxen       = ctrl_reg[CTRL_RXEN_BIT];
  assign rx_edge    = rxen ^ rxen_d_reg;
  assign thresh     = 7'(pre_det_reg[7:PREATH_LSB] * UNIT_BITS); // [R2]
  assign txon_pulse = wr_take && adr_i == CTRL_ADDR && dat_i[CTRL_TXON_BIT];

  // ack one cycle after request, dropped the cycle after; data sampled with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg & ~we_i) begin
        unique case (adr_i)
          CTRL_ADDR:       dat_reg <= {24'h0, ctrl_reg};
          STATUS_ONE_ADDR: dat_reg <= {31'h0, sticky_reg.invalid}; // [R10]
          OPFC2_ADDR:      dat_reg <= {24'h0, opfc2_reg};
          STATUS_TWO_ADDR: dat_reg <= {30'h0, sticky_reg.invalid, sticky_reg.detect}; // [R4] [R10]
          HDR_CTRL2_ADDR:  dat_reg <= {31'h0, pre_hi_reg};
          PRE_LEN_ADDR:    dat_reg <= {24'h0, pre_len_reg};
          PRE_DET_ADDR:    dat_reg <= {24'h0, pre_det_reg[7:PREATH_LSB], 3'h0};
          LIVE_ADDR:       dat_reg <= {27'h0, retx_reg, tx_reg == TX_SEND,
                                       rx_reg == RX_DATA, inv_reg, det_reg};
          default:         dat_reg <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // plain configuration registers; txon is a pulse and is not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= 8'h0;
      opfc2_reg   <= OPFC2_RST;
      pre_len_reg <= PRE_LEN_RST;
      pre_hi_reg  <= PRE_HI_RST;
      pre_det_reg <= PRE_DET_RST;
    end else if (wr_take) begin
      unique case (adr_i)
        CTRL_ADDR:      ctrl_reg <= dat_i[7:0] & 8'h05;
        OPFC2_ADDR:     opfc2_reg <= dat_i[7:0];
        HDR_CTRL2_ADDR: pre_hi_reg <= dat_i[0]; // [R1]
        PRE_LEN_ADDR:   pre_len_reg <= dat_i[7:0]; // [R1]
        PRE_DET_ADDR:   pre_det_reg <= {dat_i[7:PREATH_LSB], 3'h0};
        default:        ;
      endcase
    end
  end
  assign tx_pre_len_o = {pre_hi_reg, pre_len_reg}; // [R1]

  // sticky events, write one to clear; a same-cycle event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_reg <= '0;
    end else begin
      if (wr_take && adr_i == STATUS_TWO_ADDR && dat_i[0])
        sticky_reg.detect <= ev.detect;
      else
        sticky_reg.detect <= sticky_reg.detect | ev.detect; // [R10]
      if (wr_take && (adr_i == STATUS_ONE_ADDR || adr_i == STATUS_TWO_ADDR) &&
          dat_i[adr_i == STATUS_TWO_ADDR])
        sticky_reg.invalid <= ev.invalid;
      else
        sticky_reg.invalid <= sticky_reg.invalid | ev.invalid; // [R10] [R11]
    end
  end

  // receive search: blank, then hunt for an alternating run of threshold length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_reg       <= RX_OFF;
      rxen_d_reg   <= 1'b0;
      last_bit_reg <= 1'b0;
      run_reg      <= 7'h0;
      wait_reg     <= 6'h0;
      det_reg      <= 1'b0;
      inv_reg      <= 1'b0;
      ev           <= '0;
    end else begin
      rxen_d_reg <= rxen;
      ev         <= '0;
      if (rx_edge) begin
        // entry or exit clears flags and rearms the hunt
        rx_reg   <= rxen ? RX_BLANK : RX_OFF; // [R19]
        det_reg  <= 1'b0;
        inv_reg  <= 1'b0;
        run_reg  <= 7'h0;
        wait_reg <= 6'h0;
      end else if (rx_bit_en_i) begin
        last_bit_reg <= rx_bit_i;
        unique case (rx_reg)
          RX_OFF: ;
          RX_BLANK: begin
            // settling time: invalid held low
            wait_reg <= wait_reg + 6'h1;
            if (wait_reg == 6'(BLANK_TB - 1)) rx_reg <= RX_SRCH; // [R12]
          end
          RX_SRCH: begin
            if (rx_bit_i != last_bit_reg || run_reg == 7'h0) begin
              run_reg <= (run_reg == 7'h7f) ? run_reg : run_reg + 7'h1; // [R20]
              if (run_reg + 7'h1 >= thresh) begin
                rx_reg    <= RX_FOUND; // [R2]
                det_reg   <= 1'b1;
                inv_reg   <= 1'b0;
                ev.detect <= 1'b1;
                wait_reg  <= 6'h0;
              end
            end else begin
              // broken alternation: channel judged invalid at once
              run_reg    <= 7'h1;
              inv_reg    <= 1'b1; // [R9] [R11] [R20]
              ev.invalid <= ~inv_reg;
            end
          end
          RX_FOUND: begin
            // sync must follow within a window, else it was a false detect
            wait_reg <= wait_reg + 6'h1;
            if (sync_found_i) begin
              rx_reg <= RX_DATA; // [R18]
            end else if (wait_reg == 6'(SYNC_WAIT - 1)) begin
              rx_reg  <= RX_SRCH; // [R3]
              det_reg <= 1'b0;
              run_reg <= 7'h0;
            end
          end
          RX_DATA: ; // raw data until rx leaves [R18]
          default: rx_reg <= RX_OFF;
        endcase
      end else if (rx_reg == RX_FOUND && sync_found_i) begin
        rx_reg <= RX_DATA; // [R18]
      end
    end
  end

  // live outputs and gpio function select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preamble_detect_o       <= 1'b0;
      invalid_preamble_flag_o <= 1'b0;
      gpio_o                  <= 1'b0;
      rx_raw_o                <= 1'b0;
    end else begin
      preamble_detect_o       <= det_reg;
      invalid_preamble_flag_o <= inv_reg;
      gpio_o   <= ctrl_reg[CTRL_GSEL_BIT] ? inv_reg : det_reg; // [R4]
      rx_raw_o <= rx_reg == RX_DATA;
    end
  end

  // remember whether software loaded a packet since the last transmit
  always_ff @(posedge clk_i) begin
    if (rst_i)
      newpkt_reg <= 1'b0;
    else if (fifo_new_pkt_i)
      newpkt_reg <= 1'b1; // a load in the same cycle as tx entry survives
    else if (tx_reg == TX_IDLE && (txon_pulse || (opfc2_reg[OPFC2_AUTO_BIT] && fifo_afull_i)))
      newpkt_reg <= 1'b0;
  end

  // tx automation: txon or auto tx at almost full, back to idle when sent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg   <= TX_IDLE;
      retx_reg <= 1'b0;
      circ_reg <= 1'b0;
    end else begin
      unique case (tx_reg)
        TX_IDLE: begin
          if (txon_pulse) begin
            tx_reg   <= TX_SEND;
            retx_reg <= ~newpkt_reg & fifo_fits_i;  // [R15] [R16]
            circ_reg <= ~fifo_fits_i;               // [R16]
          end else if (opfc2_reg[OPFC2_AUTO_BIT] && fifo_afull_i) begin
            tx_reg   <= TX_SEND; // [R17]
            retx_reg <= 1'b0;
            circ_reg <= ~fifo_fits_i;
          end
        end
        TX_SEND: begin
          if (tx_done_i) begin
            tx_reg   <= TX_IDLE; // [R17]
            retx_reg <= 1'b0;
            circ_reg <= 1'b0;
          end
        end
        default: tx_reg <= TX_IDLE;
      endcase
    end
  end
  assign tx_active_o  = tx_reg[1]; // one-hot send bit, straight from the state flop
  assign retransmit_o = retx_reg;
  assign circular_o   = circ_reg;

  // assertions
  sequence s_enable;
    rx_edge && rxen;
  endsequence
  chk_blank_low: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    s_enable |=> !inv_reg [*8])
    else $error("invalid flag rose during blanking");
  chk_rearm_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    rx_edge |=> !det_reg && !inv_reg)
    else $error("flags not cleared on rx change");
  chk_detect_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    ev.detect |=> sticky_reg.detect)
    else $error("detect event lost");
  chk_invalid_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    ev.invalid |=> sticky_reg.invalid)
    else $error("invalid event lost");
  chk_error_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    rx_reg == RX_SRCH && rx_bit_en_i && !rx_edge && run_reg != 7'h0
      && rx_bit_i == last_bit_reg |=> inv_reg)
    else $error("preamble error not flagged");
  chk_gpio_sel: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    !ctrl_reg[CTRL_GSEL_BIT] |=> gpio_o == $past(det_reg))
    else $error("gpio does not show detect");
  chk_retx_fit: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    retx_reg |-> !circ_reg)
    else $error("retransmit of a packet not in fifo");
  chk_auto_tx: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    tx_reg == TX_IDLE && opfc2_reg[OPFC2_AUTO_BIT] && fifo_afull_i |=> tx_reg == TX_SEND)
    else $error("auto tx not entered");
  chk_tx_return: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    tx_reg == TX_SEND && tx_done_i |=> tx_reg == TX_IDLE ##1 !retx_reg)
    else $error("tx did not return to idle");
  chk_retx_new: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    tx_reg == TX_IDLE && txon_pulse && !newpkt_reg && fifo_fits_i |=> retx_reg)
    else $error("retransmit not started");
  chk_false_rearm: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    rx_reg == RX_FOUND && rx_bit_en_i && !rx_edge && !sync_found_i
      && wait_reg == 6'(SYNC_WAIT - 1) |=> rx_reg == RX_SRCH)
    else $error("search not resumed after false detect");

endmodule : preamble_detect_auto_tx

// ---- logic/preamble_pkg.sv ----
// shared constants, types and register map of the preamble detector and tx automation
package preamble_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR       = 8'h00; // rx enable, txon, gpio select
  localparam logic [7:0] STATUS_ONE_ADDR = 8'h04; // sticky invalid preamble, w1c
  localparam logic [7:0] OPFC2_ADDR      = 8'h08; // operating_function_control_two
  localparam logic [7:0] STATUS_TWO_ADDR = 8'h0c; // sticky preamble detect in bit 0 and invalid in bit 1, w1c
  localparam logic [7:0] HDR_CTRL2_ADDR  = 8'h10; // bit 0 holds length bit 8
  localparam logic [7:0] PRE_LEN_ADDR    = 8'h14; // length bits 7..0
  localparam logic [7:0] PRE_DET_ADDR    = 8'h18; // threshold in bits 7..3
  localparam logic [7:0] LIVE_ADDR       = 8'h1c; // live state, read only
  // field positions
  localparam int CTRL_RXEN_BIT  = 0;
  localparam int CTRL_TXON_BIT  = 1;
  localparam int CTRL_GSEL_BIT  = 2;
  localparam int OPFC2_AUTO_BIT = 3;
  localparam int PREATH_LSB     = 3;
  // reset values
  localparam logic [7:0] OPFC2_RST   = 8'h00;
  localparam logic [7:0] PRE_LEN_RST = 8'h07;
  localparam logic [7:0] PRE_DET_RST = 8'h20;
  localparam logic       PRE_HI_RST  = 1'b0;
  // timing in bit periods
  localparam int BLANK_TB  = 16; // invalid flag held low after rx enable
  localparam int UNIT_BITS = 4;  // bits per threshold unit
  localparam int SYNC_WAIT = 32; // bits allowed from detect to sync word
  // receive search states
  typedef enum logic [4:0] {
    RX_OFF   = 5'b00001,
    RX_BLANK = 5'b00010,
    RX_SRCH  = 5'b00100,
    RX_FOUND = 5'b01000,
    RX_DATA  = 5'b10000
  } rx_state_t;
  // transmit automation states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
  // event pair reported to status
  typedef struct packed {
    logic detect;
    logic invalid;
  } pre_event_t;
endpackage : preamble_pkg

// ---- sim/preamble_detect_auto_tx_tb.sv ----
// self-checking bench of the preamble detector and tx automation
`timescale 1ns/1ns
module preamble_detect_auto_tx_tb;
  import preamble_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0, rep = 0;
  logic sync_found_i = 0, fifo_new_pkt_i = 0, fifo_fits_i = 0, fifo_afull_i = 0, tx_done_i = 0;
  logic [7:0]  adr_i = 8'h00, cnt = 8'h00, rnd;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, rx_bit, rx_en, busy, det, inv, gpio_o, rx_raw_o;
  logic        tx_active_o, retransmit_o, circular_o;
  logic [8:0]  tx_pre_len_o;
  int          fails = 0, checks = 0;
  always #10 clk_i = ~clk_i;
  preamble_detect_auto_tx u_preamble_detect_auto_tx (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_bit_i(rx_bit), .rx_bit_en_i(rx_en),
    .sync_found_i(sync_found_i), .fifo_new_pkt_i(fifo_new_pkt_i), .fifo_fits_i(fifo_fits_i),
    .fifo_afull_i(fifo_afull_i), .tx_done_i(tx_done_i), .preamble_detect_o(det),
    .invalid_preamble_flag_o(inv), .gpio_o(gpio_o), .rx_raw_o(rx_raw_o),
    .tx_active_o(tx_active_o), .retransmit_o(retransmit_o), .circular_o(circular_o),
    .tx_pre_len_o(tx_pre_len_o));
  remote_tx_model u_remote_tx_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .count_i(cnt),
    .rep_i(rep), .bit_o(rx_bit), .en_o(rx_en), .busy_o(busy));
  // random source, fixed start
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // replay only when nothing new was loaded and the packet fits
  function automatic logic exp_retx(input logic nw, input logic fits);
    return !nw && fits;
  endfunction : exp_retx
  task check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task check_pin(input string nm, input logic e, input logic g);
    check_val(nm, {31'h0, e}, {31'h0, g});
  endtask : check_pin
  // one classic cycle, held until ack, then a settling gap
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    if (n >= 20) begin
      fails++;
      $display("[FAIL] ack at %h expected 1 seen 0", a);
      print_verdict();
    end
    // three edges let a control write reach the registered outputs
    repeat (3) @(posedge clk_i);
  endtask : wb
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check_val(nm, e, q);
  endtask : rd_chk
  // burst from the far end, then room for the two-stage output latency
  task send(input logic [7:0] n, input logic r);
    int k;
    k = 0;
    @(posedge clk_i);
    go <= 1; cnt <= n; rep <= r;
    @(posedge clk_i);
    go <= 0;
    // busy only shows once the model has loaded the count
    @(posedge clk_i);
    while (busy === 1'b1 && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 5000) begin
      fails++;
      $display("[FAIL] burst busy expected 0 seen 1");
      print_verdict();
    end
    repeat (3) @(posedge clk_i);
  endtask : send
  task pulse_done;
    @(posedge clk_i) tx_done_i <= 1;
    @(posedge clk_i) tx_done_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask : pulse_done
  task end_test(input string nm);
    $display("test %s done, fails %0d", nm, fails);
  endtask : end_test
  task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // hang guard, well past the fewer than one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  initial begin
    rnd = 8'h62;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    check_val("tx_pre_len_o", 32'h7, {23'h0, tx_pre_len_o});
    rd_chk("opfc2", OPFC2_ADDR, {24'h0, OPFC2_RST});
    rd_chk("pre_len", PRE_LEN_ADDR, 32'h07);
    rd_chk("pre_det", PRE_DET_ADDR, 32'h20);
    rd_chk("unmapped", 8'h20, 32'h0);
    end_test("reset");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wb(1'b1, HDR_CTRL2_ADDR, {24'h0, rnd});
      wb(1'b1, PRE_LEN_ADDR, {24'h0, ~rnd});
      check_val("tx_pre_len_o", {23'h0, rnd[0], ~rnd}, {23'h0, tx_pre_len_o});
    end
    end_test("length");
    // twenty-bit threshold for an early-enabled receiver
    wb(1'b1, PRE_DET_ADDR, 32'h5 << PREATH_LSB);
    wb(1'b1, CTRL_ADDR, 32'h1);
    send(8'(BLANK_TB + 5 * UNIT_BITS - 1), 0);
    check_pin("detect early", 0, det);
    send(8'h01, 0);
    check_pin("detect", 1, det);
    check_pin("gpio detect", 1, gpio_o);
    rd_chk("status two", STATUS_TWO_ADDR, 32'h1);
    wb(1'b1, STATUS_TWO_ADDR, 32'h1);
    rd_chk("status two w1c", STATUS_TWO_ADDR, 32'h0);
    rd_chk("live", LIVE_ADDR, 32'h1);
    send(8'(SYNC_WAIT + 1), 0);
    check_pin("false detect", 0, det);
    send(8'(5 * UNIT_BITS), 0);
    check_pin("search resumed", 1, det);
    @(posedge clk_i) sync_found_i <= 1;
    @(posedge clk_i) sync_found_i <= 0;
    repeat (3) @(posedge clk_i);
    check_pin("raw data", 1, rx_raw_o);
    wb(1'b1, CTRL_ADDR, 32'h0);
    check_pin("detect off", 0, det);
    check_pin("raw off", 0, rx_raw_o);
    end_test("detect");
    // diversity is never enabled here, so the invalid event stays usable
    wb(1'b1, CTRL_ADDR, 32'h5);
    send(8'(BLANK_TB), 1);
    check_pin("blanked", 0, inv);
    send(8'h05, 1);
    check_pin("invalid", 1, inv);
    check_pin("gpio invalid", 1, gpio_o);
    rd_chk("status one", STATUS_ONE_ADDR, 32'h1);
    rd_chk("status two", STATUS_TWO_ADDR, 32'h3);
    wb(1'b1, STATUS_ONE_ADDR, 32'h1);
    rd_chk("status one w1c", STATUS_ONE_ADDR, 32'h0);
    wb(1'b1, CTRL_ADDR, 32'h0);
    check_pin("invalid off", 0, inv);
    end_test("invalid");
    // replay, fresh packet, oversize packet
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      fifo_new_pkt_i <= (i == 1);
      fifo_fits_i    <= (i != 2);
      @(posedge clk_i) fifo_new_pkt_i <= 0;
      wb(1'b1, CTRL_ADDR, 32'h2);
      check_pin("tx active", 1, tx_active_o);
      check_pin("retransmit", exp_retx(i == 1, i != 2), retransmit_o);
      check_pin("circular", i == 2, circular_o);
      pulse_done();
      check_pin("tx idle", 0, tx_active_o);
    end
    wb(1'b1, OPFC2_ADDR, 32'h8);
    rd_chk("opfc2", OPFC2_ADDR, 32'h8);
    @(posedge clk_i) fifo_afull_i <= 1;
    repeat (3) @(posedge clk_i);
    check_pin("auto tx", 1, tx_active_o);
    fifo_afull_i <= 0;
    pulse_done();
    check_pin("auto idle", 0, tx_active_o);
    end_test("tx");
    print_verdict();
  end
endmodule : preamble_detect_auto_tx_tb

// ---- sim/remote_tx_model.sv ----
// behavioural far-end transmitter that sends preamble bits at a fixed bit rate
`timescale 1ns/1ns
module remote_tx_model (
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_i,   // synchronous reset
  input  wire logic       go_i,    // start a burst
  input  wire logic [7:0] count_i, // bits in the burst
  input  wire logic       rep_i,   // last bit repeats the one before
  output logic            bit_o,   // demodulated bit
  output logic            en_o,    // bit strobe
  output logic            busy_o   // burst in progress
);
  logic [7:0] left_reg; // bits still to send
  logic [1:0] div_reg;  // four clocks per bit period
  logic       last_reg; // last bit put on the air
  logic       nb;       // next bit, alternating unless a break is asked for
  assign nb     = (left_reg == 8'h01 && rep_i) ? last_reg : ~last_reg;
  assign busy_o = (left_reg != 8'h00) || en_o;
  // bit sequencer; between bursts the line toggles so no stale level is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_reg <= 8'h00;
      div_reg  <= 2'h0;
      last_reg <= 1'b0;
      bit_o    <= 1'b0;
      en_o     <= 1'b0;
    end else begin
      en_o <= 1'b0;
      if (left_reg == 8'h00) begin
        bit_o   <= ~bit_o;
        div_reg <= 2'h0;
        if (go_i) begin
          left_reg <= count_i;
        end
      end else begin
        div_reg <= div_reg + 2'h1;
        if (div_reg == 2'h3) begin
          en_o     <= 1'b1;
          bit_o    <= nb;
          last_reg <= nb;
          left_reg <= left_reg - 8'h01;
        end
      end
    end
  end
endmodule : remote_tx_model
